/* core/switch_forward_mac_control.sv */
// Operation
// [RULE1] Enable bit set sends unknown-VLAN frames to masked ports; clear disables it.
// [RULE2] Mask bit n selects switch port n+1; ones include, zeros exclude.
// [RULE3] Alternate back-off acts only on half-duplex ports.
// [RULE4] Software should set alternate back-off with no-excessive-collision-drop.
// [RULE5] Length check on: drop frames with field below 1500 and mismatching length.
// [RULE6] Length check off: no length comparison, frames pass.
// [RULE7] Drop mode set: drop on pause EtherType or pause address.
// [RULE8] Drop mode clear: drop only when both pause conditions match.
// [RULE9] Aggressive back-off selects non-standard half-duplex back-off.
// [RULE10] Category rank: unknown VLAN, then unicast, then multicast.
// [RULE11] Reserved read-only bits of VLAN control read zero, ignore writes.
`timescale 1ns/1ps
module switch_forward_mac_control #(
   parameter int PORTS = fwd_ctrl_pkg::PORT_COUNT
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Received frame classification
   input wire logic hdr_valid_i,
   input wire logic unk_vlan_i,
   input wire logic unk_ucast_i,
   input wire logic unk_mcast_i,
   input wire logic [15:0] etype_len_i,
   input wire logic [15:0] frame_len_i,
   input wire logic [47:0] dest_addr_i,
   // Per-port duplex (1 = half)
   input wire logic [PORTS-1:0] half_duplex_i,
   // Forwarding verdict
   output logic [PORTS-1:0] vlan_egress_o,
   output logic vlan_fwd_o,
   output logic [1:0] frame_cat_o,
   output logic drop_o,
   // Back-off selection per port
   output logic [PORTS-1:0] alt_backoff_o,
   output logic [PORTS-1:0] aggr_backoff_o
);
   logic [31:0] vlan_ctl_q;
   logic [7:0] mac_ctl0_q;
   logic [31:0] rdata_q;
   logic [PORTS-1:0] egress_q;
   logic fwd_q;
   fwd_ctrl_pkg::frame_cat_e cat_d;
   fwd_ctrl_pkg::frame_cat_e cat_q;
   logic [PORTS-1:0] alt_q;
   logic [PORTS-1:0] aggr_q;

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // True for a header that ranks as unknown VLAN while forwarding is enabled;
   // the forward flag and the egress mask share it so they can never disagree
   function automatic logic vlan_forward_hit(input logic valid,
                                             input fwd_ctrl_pkg::frame_cat_e cat,
                                             input logic [31:0] ctl);
      return valid && cat == fwd_ctrl_pkg::CAT_UNK_VLAN && ctl[fwd_ctrl_pkg::VLAN_FWD_EN_BIT];
   endfunction : vlan_forward_hit

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // [RULE11] reserved bits masked
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         vlan_ctl_q <= fwd_ctrl_pkg::VLAN_FWD_RESET;
      end else if (reg_wr_i && reg_addr_i == fwd_ctrl_pkg::VLAN_FWD_ADDR) begin
         vlan_ctl_q <= reg_wdata_i & fwd_ctrl_pkg::VLAN_FWD_WMASK;
      end
   end

   // Reserved bits of MAC control are read/write and kept as written;
   // bit 2 resets high, so software should write it back as read
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mac_ctl0_q <= fwd_ctrl_pkg::MAC_CTL0_RESET;
      end else if (reg_wr_i && reg_addr_i == fwd_ctrl_pkg::MAC_CTL0_ADDR) begin
         mac_ctl0_q <= reg_wdata_i[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // Data stands only in the cycle after the strobe; unmapped reads zero.
   // Returning zero when idle keeps a shared read bus free of stale words.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            fwd_ctrl_pkg::VLAN_FWD_ADDR: rdata_q <= vlan_ctl_q;
            fwd_ctrl_pkg::MAC_CTL0_ADDR: rdata_q <= {24'h00_0000, mac_ctl0_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end
   assign reg_rdata_o = rdata_q;

   // ----------------------------------------------------------------
   // Category ranking
   // ----------------------------------------------------------------
   // [RULE10] highest rank wins
   always_comb begin
      if (unk_vlan_i) begin
         cat_d = fwd_ctrl_pkg::CAT_UNK_VLAN;
      end else if (unk_ucast_i) begin
         cat_d = fwd_ctrl_pkg::CAT_UNK_UCAST;
      end else if (unk_mcast_i) begin
         cat_d = fwd_ctrl_pkg::CAT_UNK_MCAST;
      end else begin
         cat_d = fwd_ctrl_pkg::CAT_NONE;
      end
   end

   // [RULE1] enable gates forwarding
   // [RULE2] mask bit n is port n+1
   // Only the VLAN category is owned here; other categories leave egress empty
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         cat_q <= fwd_ctrl_pkg::CAT_NONE;
         fwd_q <= 1'b0;
         egress_q <= '0;
      end else begin
         cat_q <= hdr_valid_i ? cat_d : fwd_ctrl_pkg::CAT_NONE;
         fwd_q <= vlan_forward_hit(hdr_valid_i, cat_d, vlan_ctl_q);
         if (vlan_forward_hit(hdr_valid_i, cat_d, vlan_ctl_q)) begin
            egress_q <= vlan_ctl_q[PORTS-1:0];
         end else begin
            egress_q <= '0;
         end
      end
   end
   assign vlan_egress_o = egress_q;
   assign vlan_fwd_o = fwd_q;
   assign frame_cat_o = cat_q;

   // ----------------------------------------------------------------
   // Back-off selection
   // ----------------------------------------------------------------
   // [RULE3] half-duplex only
   // [RULE9] aggressive back-off select
   // Full-duplex ports never back off, so both selects stay low there
   genvar p;
   generate
      for (p = 0; p < PORTS; p = p + 1) begin : g_port
         always_ff @(posedge sys_clk_i) begin
            if (sys_rst_i) begin
               alt_q[p] <= 1'b0;
               aggr_q[p] <= 1'b0;
            end else begin
               alt_q[p] <= half_duplex_i[p] && mac_ctl0_q[fwd_ctrl_pkg::ALT_BACKOFF_BIT];
               aggr_q[p] <= half_duplex_i[p] && mac_ctl0_q[fwd_ctrl_pkg::AGGR_BACKOFF_BIT];
            end
         end
      end
   endgenerate
   assign alt_backoff_o = alt_q;
   assign aggr_backoff_o = aggr_q;

   // ----------------------------------------------------------------
   // Frame filter
   // ----------------------------------------------------------------
   frame_filter u_filter (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .len_check_en_i(mac_ctl0_q[fwd_ctrl_pkg::LEN_CHECK_BIT]),
      .fc_drop_mode_i(mac_ctl0_q[fwd_ctrl_pkg::FC_DROP_MODE_BIT]),
      .hdr_valid_i(hdr_valid_i),
      .etype_len_i(etype_len_i),
      .frame_len_i(frame_len_i),
      .dest_addr_i(dest_addr_i),
      .drop_o(drop_o)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Every check looks one cycle after the header, strobe or control/duplex level that it judges
   // Forwarding
   a_vlan_fwd_mask: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE2]
      (hdr_valid_i && unk_vlan_i && vlan_ctl_q[fwd_ctrl_pkg::VLAN_FWD_EN_BIT])
      |=> (vlan_fwd_o && vlan_egress_o == $past(vlan_ctl_q[PORTS-1:0])))
      else $error("unknown VLAN frame not forwarded to mask");
   a_vlan_fwd_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE1]
      (!vlan_ctl_q[fwd_ctrl_pkg::VLAN_FWD_EN_BIT]) |=> (vlan_egress_o == '0 && !vlan_fwd_o))
      else $error("forwarding while disabled");
   a_idle_no_verdict: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE1]
      (!hdr_valid_i) |=> (vlan_egress_o == '0 && !vlan_fwd_o && !drop_o
       && frame_cat_o == fwd_ctrl_pkg::CAT_NONE))
      else $error("verdict without a header");
   // Ranking
   a_rank_vlan_first: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE10]
      (hdr_valid_i && unk_vlan_i) |=> frame_cat_o == fwd_ctrl_pkg::CAT_UNK_VLAN)
      else $error("unknown VLAN did not take precedence");
   a_rank_ucast_next: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE10]
      (hdr_valid_i && !unk_vlan_i && unk_ucast_i) |=> frame_cat_o == fwd_ctrl_pkg::CAT_UNK_UCAST)
      else $error("unknown unicast did not outrank multicast");
   // Register map
   a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE11]
      (reg_rd_i && reg_addr_i == fwd_ctrl_pkg::VLAN_FWD_ADDR)
      |=> reg_rdata_o[30:7] == 24'h00_0000)
      else $error("reserved bits read nonzero");
   a_reserved_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE11]
      (reg_wr_i && reg_addr_i == fwd_ctrl_pkg::VLAN_FWD_ADDR)
      |=> vlan_ctl_q == ($past(reg_wdata_i) & fwd_ctrl_pkg::VLAN_FWD_WMASK))
      else $error("reserved VLAN control bits took a write");
   // Back-off
   a_full_duplex_std: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE3]
      $past(sys_rst_i) == 1'b0 |-> ((alt_backoff_o & ~$past(half_duplex_i)) == '0))
      else $error("alternate back-off on full-duplex port");
   a_alt_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE3]
      !$past(sys_rst_i) |-> alt_backoff_o == ($past(half_duplex_i)
       & {PORTS{$past(mac_ctl0_q[fwd_ctrl_pkg::ALT_BACKOFF_BIT])}}))
      else $error("alternate back-off does not follow control");
   a_aggr_follow: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE9]
      (half_duplex_i[0] && mac_ctl0_q[fwd_ctrl_pkg::AGGR_BACKOFF_BIT]) |=> aggr_backoff_o[0])
      else $error("aggressive back-off not applied");
endmodule : switch_forward_mac_control

/* core/fwd_ctrl_pkg.sv */
package fwd_ctrl_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [11:0] VLAN_FWD_ADDR = 12'h328;
   localparam logic [11:0] MAC_CTL0_ADDR = 12'h330;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int VLAN_FWD_EN_BIT = 31;
   localparam int PORT_COUNT = 7;
   localparam int ALT_BACKOFF_BIT = 7;
   localparam int LEN_CHECK_BIT = 3;
   localparam int FC_DROP_MODE_BIT = 1;
   localparam int AGGR_BACKOFF_BIT = 0;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] VLAN_FWD_RESET = 32'h0000_0000;
   localparam logic [7:0] MAC_CTL0_RESET = 8'h04;
   // Mask of stored bits in the VLAN control word
   localparam logic [31:0] VLAN_FWD_WMASK = 32'h8000_007F;
   // ----------------------------------------------------------------
   // Frame constants
   // ----------------------------------------------------------------
   localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05DC;
   localparam logic [15:0] PAUSE_ETYPE = 16'h8808;
   localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
   // Frame categories: none first, then highest rank first
   typedef enum logic [1:0] {
      CAT_NONE,
      CAT_UNK_VLAN,
      CAT_UNK_UCAST,
      CAT_UNK_MCAST
   } frame_cat_e;
endpackage : fwd_ctrl_pkg

/* core/frame_filter.sv */
`timescale 1ns/1ps
module frame_filter (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Configuration
   input wire logic len_check_en_i,
   input wire logic fc_drop_mode_i,
   // Frame header
   input wire logic hdr_valid_i,
   input wire logic [15:0] etype_len_i,
   input wire logic [15:0] frame_len_i,
   input wire logic [47:0] dest_addr_i,
   // Verdict
   output logic drop_o
);
   logic len_bad;
   logic etype_hit;
   logic da_hit;
   logic drop_d;
   logic drop_q;

   // ----------------------------------------------------------------
   // Header checks
   // ----------------------------------------------------------------
   // [RULE5] length mismatch discard
   // [RULE6] check off passes all
   assign len_bad = len_check_en_i && (etype_len_i < fwd_ctrl_pkg::LEN_FIELD_LIMIT)
                    && (frame_len_i != etype_len_i);
   assign etype_hit = (etype_len_i == fwd_ctrl_pkg::PAUSE_ETYPE);
   assign da_hit = (dest_addr_i == fwd_ctrl_pkg::PAUSE_DA);
   // [RULE7] either match drops
   // [RULE8] both must match
   assign drop_d = hdr_valid_i && (len_bad ||
                   (fc_drop_mode_i ? (etype_hit || da_hit) : (etype_hit && da_hit)));

   // Verdict registered so it stands for one cycle after the header
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         drop_q <= 1'b0;
      end else begin
         drop_q <= drop_d;
      end
   end
   assign drop_o = drop_q;

   // Single pause match kept in strict mode
   a_fc_both_only: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE8]
      (hdr_valid_i && !fc_drop_mode_i && !len_check_en_i && (etype_hit != da_hit))
      |=> !drop_o) else $error("single pause match dropped in strict mode");
   // Either pause match drops in loose mode
   a_fc_either_drop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE7]
      (hdr_valid_i && fc_drop_mode_i && (etype_hit || da_hit)) |=> drop_o)
      else $error("pause frame not dropped");
   // Unchecked length passes
   a_len_off_pass: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE6]
      (hdr_valid_i && !len_check_en_i && !etype_hit && !da_hit) |=> !drop_o)
      else $error("frame dropped with length check off");
   // Mismatch discarded
   a_len_bad_drop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [RULE5]
      (hdr_valid_i && len_check_en_i && etype_len_i < fwd_ctrl_pkg::LEN_FIELD_LIMIT
       && frame_len_i != etype_len_i) |=> drop_o)
      else $error("length mismatch not discarded");
endmodule : frame_filter

/* bench/test_switch_forward_mac_control.sv */
`timescale 1ns/1ps
module test_switch_forward_mac_control;
   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic hdr_valid_i = 1'b0;
   logic [2:0] flags = 3'h0;
   logic [15:0] etype_len_i = 16'h0000;
   logic [15:0] frame_len_i = 16'h0000;
   logic [47:0] dest_addr_i = 48'h0;
   logic [6:0] half_duplex_i = 7'h35;
   logic [6:0] vlan_egress_o;
   logic vlan_fwd_o;
   logic [1:0] frame_cat_o;
   logic drop_o;
   logic [6:0] alt_backoff_o;
   logic [6:0] aggr_backoff_o;
   int failures = 0;
   int compares = 0;

   // Free-running 200 MHz clock
   always #2.5 sys_clk_i = ~sys_clk_i;

   switch_forward_mac_control u_dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .hdr_valid_i(hdr_valid_i),
      .unk_vlan_i(flags[2]), .unk_ucast_i(flags[1]), .unk_mcast_i(flags[0]),
      .etype_len_i(etype_len_i), .frame_len_i(frame_len_i), .dest_addr_i(dest_addr_i),
      .half_duplex_i(half_duplex_i), .vlan_egress_o(vlan_egress_o), .vlan_fwd_o(vlan_fwd_o),
      .frame_cat_o(frame_cat_o), .drop_o(drop_o), .alt_backoff_o(alt_backoff_o),
      .aggr_backoff_o(aggr_backoff_o)
   );

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic reg_write(input logic [11:0] addr, input logic [31:0] data);
      @(posedge sys_clk_i);
      reg_addr_i <= addr;
      reg_wdata_i <= data;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask : reg_write

   // Read data stands one cycle only, so the idle cycle after is checked too
   task automatic reg_read(input logic [11:0] addr, input logic [31:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= addr;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 check(reg_rdata_o, exp);
      @(posedge sys_clk_i);
      #1 check(reg_rdata_o, 32'h0000_0000);
   endtask : reg_read

   // Expected word is {forward, egress, category, drop}
   task automatic frame(input logic [2:0] f, input logic [15:0] etl, input logic [15:0] flen,
                        input logic [47:0] da, input logic [10:0] exp);
      @(posedge sys_clk_i);
      flags <= f;
      etype_len_i <= etl;
      frame_len_i <= flen;
      dest_addr_i <= da;
      hdr_valid_i <= 1'b1;
      @(posedge sys_clk_i);
      hdr_valid_i <= 1'b0;
      #1 check({21'h0, vlan_fwd_o, vlan_egress_o, frame_cat_o, drop_o}, {21'h0, exp});
   endtask : frame

   // Back-off levels lag the control bits by one cycle
   task automatic backoff(input logic [6:0] exp_alt, input logic [6:0] exp_aggr);
      repeat (2) @(posedge sys_clk_i);
      #1 check({18'h0, alt_backoff_o, aggr_backoff_o}, {18'h0, exp_alt, exp_aggr});
   endtask : backoff

   task automatic conclude;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      reg_read(12'h328, 32'h0000_0000);
      reg_read(12'h330, 32'h0000_0004);
      reg_write(12'h328, 32'hFFFF_FFFF);
      reg_read(12'h328, 32'h8000_007F);
      reg_write(12'h32C, 32'hFFFF_FFFF);
      reg_read(12'h32C, 32'h0000_0000);
      reg_write(12'h328, 32'h8000_0055);
      frame(3'b100, 16'h0800, 16'h0040, 48'h0, {1'b1, 7'h55, 2'h1, 1'b0});
      frame(3'b111, 16'h0800, 16'h0040, 48'h0, {1'b1, 7'h55, 2'h1, 1'b0});
      frame(3'b011, 16'h0800, 16'h0040, 48'h0, {1'b0, 7'h00, 2'h2, 1'b0});
      frame(3'b001, 16'h0800, 16'h0040, 48'h0, {1'b0, 7'h00, 2'h3, 1'b0});
      frame(3'b000, 16'h0800, 16'h0040, 48'h0, {1'b0, 7'h00, 2'h0, 1'b0});
      reg_write(12'h328, 32'h8000_0040);
      frame(3'b100, 16'h0800, 16'h0040, 48'h0, {1'b1, 7'h40, 2'h1, 1'b0});
      reg_write(12'h328, 32'h0000_007F);
      frame(3'b100, 16'h0800, 16'h0040, 48'h0, {1'b0, 7'h00, 2'h1, 1'b0});
      reg_write(12'h330, 32'h0000_0008);
      frame(3'b000, 16'h0064, 16'h0063, 48'h0, {10'h0, 1'b1});
      frame(3'b000, 16'h0064, 16'h0064, 48'h0, {10'h0, 1'b0});
      frame(3'b000, 16'h05DC, 16'h0063, 48'h0, {10'h0, 1'b0});
      reg_write(12'h330, 32'h0000_0000);
      frame(3'b000, 16'h0064, 16'h0063, 48'h0, {10'h0, 1'b0});
      reg_write(12'h330, 32'h0000_0002);
      frame(3'b000, 16'h8808, 16'h0040, 48'h0, {10'h0, 1'b1});
      frame(3'b000, 16'h0800, 16'h0040, 48'h0180_C200_0001, {10'h0, 1'b1});
      reg_write(12'h330, 32'h0000_0000);
      frame(3'b000, 16'h8808, 16'h0040, 48'h0, {10'h0, 1'b0});
      frame(3'b000, 16'h0800, 16'h0040, 48'h0180_C200_0001, {10'h0, 1'b0});
      frame(3'b000, 16'h8808, 16'h0040, 48'h0180_C200_0001, {10'h0, 1'b1});
      reg_write(12'h330, 32'h0000_0081);
      reg_read(12'h330, 32'h0000_0081);
      backoff(7'h35, 7'h35);
      @(posedge sys_clk_i) half_duplex_i <= 7'h4A;
      reg_write(12'h330, 32'h0000_0080);
      backoff(7'h4A, 7'h00);
      conclude();
   end

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #20000;
      failures++;
      conclude();
   end
endmodule : test_switch_forward_mac_control
